// >>> hdl/adc_overrange_detector.sv
`timescale 1ns/10ps
`default_nettype none
module adc_overrange_detector #(
  parameter int CAL_STEP_CYCLES = adc_ovr_pkg::CAL_STEP_DEFAULT
) (
  input  wire logic                               clk_sys_i,
  input  wire logic                               sys_rst_i,
  input  wire logic                               clk_en_i,
  input  wire logic [1:0]                         variant_i,
  input  wire logic [adc_ovr_pkg::SAMPLE_W-1:0]   raw_sample_a_i,
  input  wire logic [adc_ovr_pkg::SAMPLE_W-1:0]   raw_sample_b_i,
  input  wire logic [adc_ovr_pkg::SAMPLE_W-1:0]   raw_sample_c_i,
  input  wire logic [adc_ovr_pkg::SAMPLE_W-1:0]   raw_sample_d_i,
  input  wire logic                               overrange_detect_enable_i,
  input  wire logic [adc_ovr_pkg::MAG_W-1:0]      overrange_threshold_i,
  input  wire logic [adc_ovr_pkg::HOLD_SEL_W-1:0] overrange_hold_select_i,
  input  wire logic                               trim_wr_i,
  input  wire logic [adc_ovr_pkg::TRIM_IDX_W-1:0] trim_index_i,
  input  wire logic [adc_ovr_pkg::TRIM_W-1:0]     trim_value_i,
  input  wire logic                               cal_start_i,
  input  wire logic                               cal_background_i,
  output var  logic [adc_ovr_pkg::SAMPLE_W-1:0]   sample_a_o,
  output var  logic [adc_ovr_pkg::SAMPLE_W-1:0]   sample_b_o,
  output var  logic [adc_ovr_pkg::SAMPLE_W-1:0]   sample_c_o,
  output var  logic [adc_ovr_pkg::SAMPLE_W-1:0]   sample_d_o,
  output var  logic                               sample_valid_o,
  output var  logic                               overrange_out_a_o,
  output var  logic                               overrange_out_b_o,
  output var  logic                               overrange_out_c_o,
  output var  logic                               overrange_out_d_o,
  output var  logic                               cal_busy_o,
  output var  logic                               cal_done_o,
  output var  logic [adc_ovr_pkg::CORE_W-1:0]     core_under_cal_o
);

  localparam int NCH  = adc_ovr_pkg::NUM_CH;
  localparam int SW   = adc_ovr_pkg::SAMPLE_W;
  localparam int TW   = adc_ovr_pkg::TRIM_W;
  localparam int CW   = adc_ovr_pkg::CORE_W;
  localparam int IW   = adc_ovr_pkg::TRIM_IDX_W;
  localparam int CNTW = adc_ovr_pkg::CAL_CNT_W;

  // ==========================================================
  // Helpers
  function automatic logic [CW-1:0] core_count(input logic [1:0] v);
    case (v)
      adc_ovr_pkg::VAR_QUAD: core_count = adc_ovr_pkg::CORES_QUAD;
      adc_ovr_pkg::VAR_DUAL: core_count = adc_ovr_pkg::CORES_DUAL;
      default:               core_count = adc_ovr_pkg::CORES_SINGLE;
    endcase
  endfunction

  // Trim is signed; the sum saturates rather than wrapping past full scale
  function automatic logic [SW-1:0] trim_add(input logic [SW-1:0] s,
                                             input logic [TW-1:0] t);
    logic [SW:0] sum;
    sum = {s[SW-1], s} + {{(SW + 1 - TW){t[TW-1]}}, t};
    if (sum[SW] != sum[SW-1]) begin
      trim_add = sum[SW] ? adc_ovr_pkg::SAMPLE_MIN
                         : adc_ovr_pkg::SAMPLE_MAX;
    end else begin
      trim_add = sum[SW-1:0];
    end
  endfunction

  // ==========================================================
  // Calibration sequencer
  adc_ovr_pkg::cal_state_t cal_state;
  adc_ovr_pkg::cal_state_t next_cal_state;
  logic [CW-1:0]   cal_core;
  logic [CW-1:0]   next_cal_core;
  logic [CNTW-1:0] cal_cnt;
  logic [CNTW-1:0] next_cal_cnt;
  logic            next_cal_done;
  logic            step_end;
  logic            last_core;

  always_comb begin
    step_end  = (cal_cnt == CNTW'(CAL_STEP_CYCLES - 1));
    last_core = (cal_core == core_count(variant_i) - 1'b1);
    next_cal_state = cal_state;
    next_cal_core  = cal_core;
    next_cal_cnt   = cal_cnt;
    next_cal_done  = 1'b0;
    case (cal_state)
      adc_ovr_pkg::CAL_IDLE: begin
        next_cal_core = '0;
        next_cal_cnt  = '0;
        if (cal_start_i) begin
          next_cal_state = adc_ovr_pkg::CAL_FORE;
        end else if (cal_background_i) begin
          next_cal_state = adc_ovr_pkg::CAL_BACK;
        end
      end
      adc_ovr_pkg::CAL_FORE: begin
        next_cal_cnt = step_end ? '0 : cal_cnt + 1'b1;
        if (step_end && last_core) begin
          next_cal_state = adc_ovr_pkg::CAL_IDLE;
          next_cal_core  = '0;
          next_cal_done  = 1'b1;
        end else if (step_end) begin
          next_cal_core = cal_core + 1'b1;
        end
      end
      adc_ovr_pkg::CAL_BACK: begin
        // Rotate through every core, leaving only at a step boundary
        next_cal_cnt = step_end ? '0 : cal_cnt + 1'b1;
        if (step_end) begin
          next_cal_core = last_core ? '0 : cal_core + 1'b1;
          if (!cal_background_i) begin
            next_cal_state = adc_ovr_pkg::CAL_IDLE;
            next_cal_core  = '0;
            next_cal_done  = 1'b1;
          end
        end
      end
      default: begin
        next_cal_state = adc_ovr_pkg::CAL_IDLE;
        next_cal_core  = '0;
        next_cal_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cal_state  <= adc_ovr_pkg::CAL_IDLE;
      cal_core   <= '0;
      cal_cnt    <= '0;
      cal_done_o <= 1'b0;
      cal_busy_o <= 1'b0;
    end else if (clk_en_i) begin
      cal_state  <= next_cal_state;
      cal_core   <= next_cal_core;
      cal_cnt    <= next_cal_cnt;
      cal_done_o <= next_cal_done;
      cal_busy_o <= (next_cal_state != adc_ovr_pkg::CAL_IDLE);
    end
  end

  assign core_under_cal_o = cal_core;

  // ==========================================================
  // Offset trim table and channel enables
  logic [TW-1:0]  trim_mem      [adc_ovr_pkg::TRIM_SLOTS];
  logic [TW-1:0]  next_trim_mem [adc_ovr_pkg::TRIM_SLOTS];
  logic [NCH-1:0] ch_en;
  logic [NCH-1:0] next_ch_en;

  always_comb begin
    next_trim_mem = trim_mem;
    if (trim_wr_i) begin
      next_trim_mem[trim_index_i] = trim_value_i;
    end
    case (variant_i)
      adc_ovr_pkg::VAR_QUAD: next_ch_en = adc_ovr_pkg::CH_EN_QUAD;
      adc_ovr_pkg::VAR_DUAL: next_ch_en = adc_ovr_pkg::CH_EN_DUAL;
      default:               next_ch_en = adc_ovr_pkg::CH_EN_SINGLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < adc_ovr_pkg::TRIM_SLOTS; i++) begin
        trim_mem[i] <= '0;
      end
      ch_en <= '0;
    end else if (clk_en_i) begin
      trim_mem <= next_trim_mem;
      ch_en    <= next_ch_en;
    end
  end

  // ==========================================================
  // Sample pipeline: capture, code conversion, trim
  logic [SW-1:0]  raw       [NCH];
  logic [SW-1:0]  cap       [NCH];
  logic [SW-1:0]  next_cap  [NCH];
  logic [SW-1:0]  samp      [NCH];
  logic [SW-1:0]  next_samp [NCH];
  logic [NCH-1:0] on_spare;
  logic [IW-1:0]  slot      [NCH];
  logic           next_valid;

  assign raw[0] = raw_sample_a_i;
  assign raw[1] = raw_sample_b_i;
  assign raw[2] = raw_sample_c_i;
  assign raw[3] = raw_sample_d_i;

  always_comb begin
    for (int ch = 0; ch < NCH; ch++) begin
      // A channel whose own core is out for background calibration runs on the spare
      on_spare[ch] = (cal_state == adc_ovr_pkg::CAL_BACK) &&
        (cal_core == adc_ovr_pkg::PRIMARY_CORES[ch*CW +: CW]);
      slot[ch] = on_spare[ch] ? adc_ovr_pkg::TRIM_SPARE[ch*IW +: IW]
                              : adc_ovr_pkg::TRIM_PRIMARY[ch*IW +: IW];
      next_cap[ch]  = raw[ch];
      next_samp[ch] = trim_add(cap[ch] ^ adc_ovr_pkg::OB_SIGN_FLIP,
                               trim_mem[slot[ch]]);
    end
    next_valid = (next_cal_state != adc_ovr_pkg::CAL_FORE);
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int ch = 0; ch < NCH; ch++) begin
        // Midscale code, so the first sample after reset reads as zero
        cap[ch]  <= adc_ovr_pkg::OB_SIGN_FLIP;
        samp[ch] <= '0;
      end
      sample_valid_o <= 1'b0;
    end else if (clk_en_i) begin
      cap            <= next_cap;
      samp           <= next_samp;
      sample_valid_o <= next_valid;
    end
  end

  assign sample_a_o = samp[0];
  assign sample_b_o = samp[1];
  assign sample_c_o = samp[2];
  assign sample_d_o = samp[3];

  // ==========================================================
  // Over-range channels, one shared threshold
  logic [NCH-1:0] ovr;

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    overrange_channel u_ch (
      .clk_sys_i       (clk_sys_i),
      .sys_rst_i       (sys_rst_i),
      .clk_en_i        (clk_en_i),
      .chan_en_i       (ch_en[g]),
      .detect_enable_i (overrange_detect_enable_i),
      .sample_valid_i  (sample_valid_o),
      .sample_i        (samp[g]),
      .threshold_i     (overrange_threshold_i),
      .hold_select_i   (overrange_hold_select_i),
      .overrange_o     (ovr[g])
    );
  end

  // Flags leave straight from the channel flip-flops
  assign overrange_out_a_o = ovr[0];
  assign overrange_out_b_o = ovr[1];
  assign overrange_out_c_o = ovr[2];
  assign overrange_out_d_o = ovr[3];

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  AST_FG_HALT: assert property (
    cal_state == adc_ovr_pkg::CAL_FORE |-> !sample_valid_o)
    else $error("samples valid during foreground calibration");

  AST_BG_RUNS: assert property (
    cal_state == adc_ovr_pkg::CAL_BACK && $past(cal_state) ==
    adc_ovr_pkg::CAL_BACK |-> sample_valid_o)
    else $error("background calibration stopped the samples");

  AST_SINGLE_PINS: assert property (
    variant_i == adc_ovr_pkg::VAR_SINGLE [*3]
    |-> !overrange_out_b_o && !overrange_out_c_o && !overrange_out_d_o)
    else $error("unused over-range pin active in single variant");

  AST_FG_LENGTH: assert property (
    cal_state == adc_ovr_pkg::CAL_FORE |-> cal_core < core_count(variant_i))
    else $error("calibration core index beyond the core count");

  COV_FG_DONE: cover property (cal_done_o && $past(cal_state) ==
    adc_ovr_pkg::CAL_FORE);
  COV_SPARE_A: cover property (on_spare[0] && overrange_out_a_o);
  COV_QUAD_D: cover property (overrange_out_d_o);

endmodule
`default_nettype wire

// >>> include/adc_ovr_pkg.sv
package adc_ovr_pkg;

  // ==========================================================
  // Widths and sizes
  localparam int NUM_CH          = 4;
  localparam int SAMPLE_W        = 9;
  localparam int MAG_W           = 8;
  localparam int HOLD_SEL_W      = 3;
  localparam int HOLD_CNT_W      = 10;
  localparam int HOLD_LEN_W      = HOLD_CNT_W + 1;
  localparam int HOLD_BASE_SHIFT = 3;
  localparam int TRIM_W          = 6;
  localparam int TRIM_SLOTS      = 8;
  localparam int TRIM_IDX_W      = 3;
  localparam int CORE_W          = 3;
  localparam int CAL_CNT_W       = 16;
  localparam int CAL_STEP_DEFAULT = 1024;

  // ==========================================================
  // Sample codes
  localparam logic [SAMPLE_W-1:0] SAMPLE_MAX   = 9'h0ff;
  localparam logic [SAMPLE_W-1:0] SAMPLE_MIN   = 9'h100;
  localparam logic [SAMPLE_W-1:0] SAMPLE_ONE   = 9'h001;
  localparam logic [SAMPLE_W-1:0] OB_SIGN_FLIP = 9'h100;
  localparam logic [MAG_W-1:0]    MAG_MAX      = 8'hff;

  // ==========================================================
  // Core map, per channel D..A from the top
  localparam logic [CORE_W-1:0] CORES_QUAD   = 3'h6;
  localparam logic [CORE_W-1:0] CORES_DUAL   = 3'h3;
  localparam logic [CORE_W-1:0] CORES_SINGLE = 3'h2;
  localparam logic [NUM_CH*CORE_W-1:0] PRIMARY_CORES =
    {3'h5, 3'h4, 3'h1, 3'h0};
  localparam logic [NUM_CH*TRIM_IDX_W-1:0] TRIM_PRIMARY =
    {3'h7, 3'h6, 3'h1, 3'h0};
  localparam logic [NUM_CH*TRIM_IDX_W-1:0] TRIM_SPARE =
    {3'h5, 3'h4, 3'h3, 3'h2};
  localparam logic [NUM_CH-1:0] CH_EN_QUAD   = 4'hf;
  localparam logic [NUM_CH-1:0] CH_EN_DUAL   = 4'h3;
  localparam logic [NUM_CH-1:0] CH_EN_SINGLE = 4'h1;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    VAR_QUAD   = 2'h0,
    VAR_DUAL   = 2'h1,
    VAR_SINGLE = 2'h2
  } variant_t;

  typedef enum logic [2:0] {
    CAL_IDLE = 3'h1,
    CAL_FORE = 3'h2,
    CAL_BACK = 3'h4
  } cal_state_t;

  // ==========================================================
  // Shared arithmetic
  function automatic logic [MAG_W-1:0] magnitude(
    input logic [SAMPLE_W-1:0] s);
    logic [SAMPLE_W-1:0] neg;
    neg = ~s + SAMPLE_ONE;
    if (!s[SAMPLE_W-1]) begin
      magnitude = s[MAG_W-1:0];
    end else if (neg[SAMPLE_W-1]) begin
      // Most negative code folds onto the top of the range
      magnitude = MAG_MAX;
    end else begin
      magnitude = neg[MAG_W-1:0];
    end
  endfunction

  function automatic logic [HOLD_LEN_W-1:0] hold_len(
    input logic [HOLD_SEL_W-1:0] sel);
    hold_len = HOLD_LEN_W'(1) << (HOLD_BASE_SHIFT + int'(sel));
  endfunction

endpackage

// >>> hdl/overrange_channel.sv
`timescale 1ns/10ps
`default_nettype none
module overrange_channel (
  input  wire logic                               clk_sys_i,
  input  wire logic                               sys_rst_i,
  input  wire logic                               clk_en_i,
  input  wire logic                               chan_en_i,
  input  wire logic                               detect_enable_i,
  input  wire logic                               sample_valid_i,
  input  wire logic [adc_ovr_pkg::SAMPLE_W-1:0]   sample_i,
  input  wire logic [adc_ovr_pkg::MAG_W-1:0]      threshold_i,
  input  wire logic [adc_ovr_pkg::HOLD_SEL_W-1:0] hold_select_i,
  output var  logic                               overrange_o
);

  logic [adc_ovr_pkg::MAG_W-1:0]      mag;
  logic                               hit;
  logic                               active;
  logic [adc_ovr_pkg::HOLD_CNT_W-1:0] hold_cnt;
  logic [adc_ovr_pkg::HOLD_CNT_W-1:0] next_hold_cnt;
  logic                               next_overrange;
  logic [adc_ovr_pkg::HOLD_LEN_W-1:0] len;

  // ==========================================================
  // Detection
  always_comb begin
    mag    = adc_ovr_pkg::magnitude(sample_i);
    active = detect_enable_i && chan_en_i;
    hit    = active && sample_valid_i && (mag >= threshold_i);
    len    = adc_ovr_pkg::hold_len(hold_select_i);
    next_hold_cnt  = hold_cnt;
    next_overrange = overrange_o;
    if (!active) begin
      next_hold_cnt  = '0;
      next_overrange = 1'b0;
    end else if (hit) begin
      // Any crossing reloads the full count
      next_hold_cnt  = adc_ovr_pkg::HOLD_CNT_W'(len - 1'b1);
      next_overrange = 1'b1;
    end else if (hold_cnt != '0) begin
      next_hold_cnt  = hold_cnt - 1'b1;
    end else begin
      next_overrange = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_cnt    <= '0;
      overrange_o <= 1'b0;
    end else if (clk_en_i) begin
      hold_cnt    <= next_hold_cnt;
      overrange_o <= next_overrange;
    end
  end

  // ==========================================================
  // Checks
  logic [adc_ovr_pkg::HOLD_LEN_W-1:0] age;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      age <= '0;
    end else if (clk_en_i) begin
      if (hit) begin
        age <= '0;
      end else if (age != '1) begin
        age <= age + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  AST_HIT_SETS: assert property (clk_en_i && hit |=> overrange_o)
    else $error("crossing did not raise the flag");

  AST_OFF_LOW: assert property (clk_en_i && !active |=> !overrange_o)
    else $error("flag high while detection is off");

  AST_HOLD_LEN: assert property (
    $fell(overrange_o) && $past(active) && $stable(hold_select_i)
    |-> age == len)
    else $error("pulse length differs from the selected hold");

  AST_RELOAD: assert property (
    clk_en_i && hit |=> hold_cnt == adc_ovr_pkg::HOLD_CNT_W'(
      $past(len) - 1'b1))
    else $error("crossing did not reload the hold counter");

  AST_MAG_ENDS: assert property (
    (sample_i == adc_ovr_pkg::SAMPLE_MIN |-> mag == adc_ovr_pkg::MAG_MAX)
    and (sample_i == adc_ovr_pkg::SAMPLE_MAX |-> mag == adc_ovr_pkg::MAG_MAX)
    and (sample_i == '0 |-> mag == '0))
    else $error("magnitude of an end code is wrong");

  COV_RETRIGGER: cover property (overrange_o && hit && hold_cnt != '0);
  COV_PULSE_END: cover property ($fell(overrange_o) && active);

endmodule
`default_nettype wire

// >>> tb/gain_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Downstream gain control: counts flag rises, cuts gain on any flag
module gain_ctrl_model (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic [3:0]  overrange_i,
  output var  logic [15:0] rise_count_o,
  output var  logic        gain_cut_o
);
  logic [3:0]  prev;
  logic [3:0]  next_prev;
  logic [15:0] next_rise_count;
  logic        next_gain_cut;

  always_comb begin
    next_prev       = overrange_i;
    next_rise_count = rise_count_o + 16'($countones(overrange_i & ~prev));
    next_gain_cut   = |overrange_i;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev         <= 4'h0;
      rise_count_o <= 16'h0;
      gain_cut_o   <= 1'b0;
    end else begin
      prev         <= next_prev;
      rise_count_o <= next_rise_count;
      gain_cut_o   <= next_gain_cut;
    end
  end
endmodule
`default_nettype wire

// >>> tb/adc_overrange_detector_bench.sv
`timescale 1ns/10ps
`default_nettype none
module adc_overrange_detector_bench;
  localparam int         STEP = 4;
  localparam logic [8:0] IDLE = 9'h100;
  localparam logic [8:0] CODES [5] = '{9'h1ff, 9'h1fe, 9'h100, 9'h002, 9'h000};
  localparam logic [7:0] MAGS [5]  = '{8'hff, 8'hfe, 8'h00, 8'hfe, 8'hff};
  localparam int         NCORE [3] = '{6, 3, 2};
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        clk_en    = 1'b1;
  logic [1:0]  variant   = 2'h0;
  logic [8:0]  raw [4]   = '{default: 9'h100};
  logic        det_en    = 1'b0;
  logic [7:0]  thresh    = 8'hff;
  logic [2:0]  hold_sel  = 3'h0;
  logic        trim_wr   = 1'b0;
  logic [2:0]  trim_idx  = 3'h0;
  logic [5:0]  trim_val  = 6'h00;
  logic        cal_start = 1'b0;
  logic        cal_bg    = 1'b0;
  wire  [8:0]  smp [4];
  wire  [3:0]  flags;
  wire         valid;
  wire         busy;
  wire         done;
  wire  [2:0]  core;
  wire  [15:0] rises;
  int          err_total = 0;
  int          checked   = 0;
  int          first;
  int          span;
  int          bsy;
  logic [3:0]  others;
  logic [15:0] rise0;
  logic [2:0]  maxc;
  logic        seen;
  logic        dn;
  int          nsp;
  wire         cut;

  always #2.5 clk_sys_i = ~clk_sys_i;

  adc_overrange_detector #(.CAL_STEP_CYCLES(STEP)) i_dut (
    .clk_sys_i                (clk_sys_i),
    .sys_rst_i                (sys_rst_i),
    .clk_en_i                 (clk_en),
    .variant_i                (variant),
    .raw_sample_a_i           (raw[0]),
    .raw_sample_b_i           (raw[1]),
    .raw_sample_c_i           (raw[2]),
    .raw_sample_d_i           (raw[3]),
    .overrange_detect_enable_i(det_en),
    .overrange_threshold_i    (thresh),
    .overrange_hold_select_i  (hold_sel),
    .trim_wr_i                (trim_wr),
    .trim_index_i             (trim_idx),
    .trim_value_i             (trim_val),
    .cal_start_i              (cal_start),
    .cal_background_i         (cal_bg),
    .sample_a_o               (smp[0]),
    .sample_b_o               (smp[1]),
    .sample_c_o               (smp[2]),
    .sample_d_o               (smp[3]),
    .sample_valid_o           (valid),
    .overrange_out_a_o        (flags[0]),
    .overrange_out_b_o        (flags[1]),
    .overrange_out_c_o        (flags[2]),
    .overrange_out_d_o        (flags[3]),
    .cal_busy_o               (busy),
    .cal_done_o               (done),
    .core_under_cal_o         (core)
  );

  gain_ctrl_model i_gain (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .overrange_i (flags),
    .rise_count_o(rises),
    .gain_cut_o  (cut)
  );

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One-cycle hit, optional second hit at gap; measures flag span
  task automatic burst(input int ch, input logic [8:0] code, input int gap);
    first = -1;
    span = 0;
    others = 4'h0;
    raw[ch] = code;
    for (int k = 1; k < 1200; k++) begin
      @(negedge clk_sys_i);
      raw[ch] = (k == gap) ? code : IDLE;
      others = others | (flags & ~(4'h1 << ch));
      if (k == 2) check(16'(smp[ch]), 16'(code ^ 9'h100));
      if (flags[ch] === 1'b1) begin
        span++;
        if (first < 0) first = k;
      end else if (first >= 0 || k > gap + 8) begin
        break;
      end
    end
  endtask

  // ==========================================================
  // Sequence
  initial begin
    repeat (8) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    @(negedge clk_sys_i);
    // Trim reset value is not relied on: clear every slot first
    trim_wr = 1'b1;
    for (int i = 0; i < 8; i++) begin
      trim_idx = 3'(i);
      @(negedge clk_sys_i);
    end
    trim_wr = 1'b0;
    det_en = 1'b1;
    for (int i = 0; i < 5; i++) begin
      thresh = (MAGS[i] == 8'h00) ? 8'h01 : MAGS[i];
      burst(0, CODES[i], 0);
      check(16'(span), (MAGS[i] == 8'h00) ? 16'h0 : 16'h8);
      if (MAGS[i] != 8'hff && MAGS[i] != 8'h00) begin
        thresh = MAGS[i] + 8'h01;
        burst(0, CODES[i], 0);
        check(16'(span), 16'h0);
      end
    end
    thresh = 8'hc8;
    raw = '{9'h1c8, 9'h1c7, 9'h038, 9'h039};
    @(negedge clk_sys_i);
    raw = '{default: IDLE};
    repeat (2) @(negedge clk_sys_i);
    check(16'(flags), 16'h5);
    repeat (10) @(negedge clk_sys_i);
    thresh = 8'he4;
    for (int ch = 0; ch < 4; ch++) begin
      burst(ch, 9'h000, 0);
      check(16'(span), 16'h8);
      check(16'(others), 16'h0);
    end
    for (int s = 0; s < 8; s++) begin
      hold_sel = 3'(s);
      rise0 = rises;
      burst(0, 9'h1ff, 0);
      check(16'(span), 16'(8 << s));
      check(16'(first), 16'h3);
      check(rises - rise0, 16'h1);
    end
    hold_sel = 3'h0;
    burst(1, 9'h1ff, 5);
    check(16'(span), 16'hd);
    burst(1, 9'h1ff, 8);
    check(16'(span), 16'h10);
    // Clock enable low freezes the hold count in mid-pulse
    raw[1] = 9'h1ff;
    @(negedge clk_sys_i);
    raw[1] = IDLE;
    repeat (3) @(negedge clk_sys_i);
    clk_en = 1'b0;
    repeat (20) @(negedge clk_sys_i);
    check(16'(flags[1]), 16'h1);
    clk_en = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    check(16'(flags[1]), 16'h1);
    @(negedge clk_sys_i);
    check(16'(flags[1]), 16'h0);
    det_en = 1'b0;
    burst(2, 9'h1ff, 0);
    check(16'(span), 16'h0);
    det_en = 1'b1;
    hold_sel = 3'h7;
    raw[2] = 9'h1ff;
    @(negedge clk_sys_i);
    raw[2] = IDLE;
    repeat (3) @(negedge clk_sys_i);
    check(16'(flags[2]), 16'h1);
    check(16'(cut), 16'h1);
    det_en = 1'b0;
    @(negedge clk_sys_i);
    check(16'(flags[2]), 16'h0);
    det_en = 1'b1;
    hold_sel = 3'h0;
    for (int v = 1; v < 3; v++) begin
      variant = 2'(v);
      repeat (3) @(negedge clk_sys_i);
      raw = '{default: 9'h1ff};
      @(negedge clk_sys_i);
      raw = '{default: IDLE};
      repeat (2) @(negedge clk_sys_i);
      check(16'(flags), (v == 1) ? 16'h3 : 16'h1);
      repeat (10) @(negedge clk_sys_i);
    end
    for (int v = 0; v < 3; v++) begin
      variant = 2'(v);
      @(negedge clk_sys_i);
      raw[0] = 9'h1ff;
      cal_start = 1'b1;
      @(negedge clk_sys_i);
      cal_start = 1'b0;
      bsy = 0;
      maxc = 3'h0;
      seen = 1'b0;
      for (int k = 0; k < 100 && busy === 1'b1; k++) begin
        bsy++;
        seen = seen | (flags[0] === 1'b1) | (valid !== 1'b0);
        if (core > maxc) maxc = core;
        @(negedge clk_sys_i);
      end
      check(16'(bsy), 16'(NCORE[v] * STEP));
      check(16'(maxc), 16'(NCORE[v] - 1));
      check(16'(seen), 16'h0);
      check(16'(done), 16'h1);
      raw[0] = IDLE;
      repeat (12) @(negedge clk_sys_i);
    end
    // Spare trim for channel A shows only while its core is out
    trim_wr = 1'b1;
    trim_idx = 3'h2;
    trim_val = 6'h05;
    @(negedge clk_sys_i);
    trim_wr = 1'b0;
    variant = 2'h0;
    cal_bg = 1'b1;
    bsy = 0;
    nsp = 0;
    seen = 1'b0;
    repeat (30) begin
      @(negedge clk_sys_i);
      if (busy === 1'b1) bsy++;
      if (smp[0] === 9'h005) nsp++;
      seen = seen | (valid !== 1'b1);
    end
    cal_bg = 1'b0;
    dn = 1'b0;
    repeat (40) begin
      @(negedge clk_sys_i);
      if (done === 1'b1) dn = 1'b1;
    end
    check(16'(bsy > 0), 16'h1);
    check(16'(nsp), 16'(2 * STEP));
    check(16'(seen), 16'h0);
    check(16'(dn), 16'h1);
    trim_wr = 1'b1;
    trim_idx = 3'h0;
    trim_val = 6'h03;
    @(negedge clk_sys_i);
    trim_idx = 3'h7;
    trim_val = 6'h3d;
    @(negedge clk_sys_i);
    trim_wr = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    check(16'(smp[0]), 16'h003);
    check(16'(smp[3]), 16'h1fd);
    raw[0] = 9'h1ff;
    repeat (3) @(negedge clk_sys_i);
    check(16'(smp[0]), 16'h0ff);
    tally_and_finish();
  end

  // ==========================================================
  // Watchdog, well beyond the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
